// File: rtl/dma_err_pkg.sv
// Purpose: Shared constants and types for the DMA error handler.
// Assumes: One core clock, synchronous active-low reset.
// Notes:   Flag bit positions double as write-one-to-clear positions.
package dma_err_pkg;
	localparam int          FLAG_W      = 6;
	localparam int          F_DPE       = 0;
	localparam int          F_MEMORY_ERROR_FLAG      = 1;
	localparam int          F_CORRECTABLE_READ_FLAG      = 2;
	localparam int          F_UNCORRECTABLE_READ_FLAG      = 3;
	localparam int          F_INVALID_MAP_ENTRY_FLAG      = 4;
	localparam int          F_LOST      = 5;
	localparam int          PCI_AW      = 32;
	localparam int          HOST_AW     = 34;
	localparam int          WB_ENTRIES  = 2;
	localparam int          PERR_DELAY  = 2;
	localparam int          SB_UNCORR   = 0;
	localparam int          SB_CORR     = 1;
	localparam int          CMD_WR_BIT  = 0;
	localparam logic [1:0]  ACK_DMA_ERR = 2'h3;
	localparam logic [1:0]  ACK_MAP_ERR = 2'h2;
	localparam logic [5:0]  FLAGS_RST   = 6'h00;
	localparam logic [31:0] PCI_ERROR_ADDRESS_REG_RST    = 32'h0000_0000;
	localparam logic [33:0] HOST_BUS_ERROR_ADDRESS_REG_RST    = 34'h0_0000_0000;

	typedef logic [FLAG_W-1:0] flag_vec_t;

	typedef enum logic [2:0] {
		TS_IDLE  = 3'b001,
		TS_READ  = 3'b010,
		TS_WRITE = 3'b100
	} txn_state_t;
endpackage : dma_err_pkg

// File: rtl/err_flag_if.sv
// Purpose: Carries flag set, clear and state between handler and bank.
// Assumes: Set and clear are one-cycle vectors in the core clock domain.
// Notes:   The bank owns the flags; the handler only requests changes.
`timescale 1ns/1ps
`default_nettype none
interface err_flag_if;
	import dma_err_pkg::*;
	flag_vec_t set_vec;
	flag_vec_t clr_vec;
	flag_vec_t flags;
	modport bank (input set_vec, input clr_vec, output flags);
	modport user (output set_vec, output clr_vec, input flags);
endinterface : err_flag_if
`default_nettype wire

// File: rtl/err_flag_bank.sv
// Purpose: Sticky error flags with write-one-to-clear.
// Assumes: Requests arrive through err_flag_if.
// Notes:   A set in the same cycle as its clear wins.
`timescale 1ns/1ps
`default_nettype none
module err_flag_bank (
	input wire logic   core_clk,
	input wire logic   rst_n,
	err_flag_if.bank   fl
);
	import dma_err_pkg::*;

	flag_vec_t flags_reg;
	flag_vec_t flags_next;

	genvar i;
	generate
		for (i = 0; i < FLAG_W; i++) begin : g_flag
			always_comb begin
				flags_next[i] = (flags_reg[i] & ~fl.clr_vec[i]) | fl.set_vec[i];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flags_reg <= FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign fl.flags = flags_reg;
endmodule : err_flag_bank
`default_nettype wire

// File: rtl/dma_par_check.sv
// Purpose: PCI parity compare and delayed PERR# drive.
// Assumes: PAR is presented aligned with the AD and C/BE# it covers.
// Notes:   The pin output is active low; enable is high while driving.
`timescale 1ns/1ps
`default_nettype none
module dma_par_check (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [31:0]       pci_ad,
	input  wire logic [3:0]        pci_cbe_n,
	input  wire logic              pci_par,
	input  wire logic              data_err,
	output wire logic              mismatch,
	output var  logic              perr_n_o,
	output var  logic              perr_oe
);
	import dma_err_pkg::*;

	logic [PERR_DELAY-2:0] pipe_reg;
	logic [PERR_DELAY-2:0] pipe_next;
	logic                  perr_n_next;
	logic                  perr_oe_next;

	// Even parity: the XOR of all covered lines and PAR must be zero.
	assign mismatch = ^{pci_ad, pci_cbe_n, pci_par};

	always_comb begin
		pipe_next    = pipe_reg;
		pipe_next[0] = data_err;
		for (int k = 1; k < PERR_DELAY - 1; k++) begin
			pipe_next[k] = pipe_reg[k-1];
		end
		perr_n_next  = ~pipe_reg[PERR_DELAY-2];
		perr_oe_next = pipe_reg[PERR_DELAY-2];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pipe_reg <= '0;
			perr_n_o <= 1'b1;
			perr_oe  <= 1'b0;
		end else begin
			pipe_reg <= pipe_next;
			perr_n_o <= perr_n_next;
			perr_oe  <= perr_oe_next;
		end
	end
endmodule : dma_par_check
`default_nettype wire

// File: rtl/pci_dma_error_handler.sv
// Purpose: Error detection and reporting for PCI-initiated DMA.
// Assumes: All inputs synchronous to core_clk (25 MHz).
// Notes:   Error logging is frozen while any error flag other than the lost flag is set.
`timescale 1ns/1ps
`default_nettype none
module pci_dma_error_handler #(
	parameter int WB_N = dma_err_pkg::WB_ENTRIES
) (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic                         addr_valid,
	input  wire logic                         addr_hit,
	input  wire logic [31:0]                  pci_ad,
	input  wire logic [3:0]                   pci_cbe_n,
	input  wire logic                         pci_par,
	input  wire logic                         data_valid,
	input  wire logic                         txn_end,
	input  wire logic [$clog2(WB_N)-1:0]      wr_entry,
	input  wire logic                         hb_done,
	input  wire logic [1:0]                   dma_cycle_ack,
	input  wire logic                         hb_map_read,
	input  wire logic                         hb_for_read,
	input  wire logic                         hb_needed,
	input  wire logic [$clog2(WB_N)-1:0]      hb_entry,
	input  wire logic [dma_err_pkg::HOST_AW-1:0] hb_addr,
	input  wire logic                         lw_valid,
	input  wire logic [1:0]                   datapath_error_sideband,
	input  wire logic                         lw_to_pci,
	input  wire logic                         lw_for_read,
	input  wire logic                         lw_rmw,
	input  wire logic [$clog2(WB_N)-1:0]      lw_entry,
	input  wire logic [dma_err_pkg::HOST_AW-1:0] lw_addr,
	input  wire logic                         map_invalid,
	input  wire logic                         map_for_read,
	input  wire logic [$clog2(WB_N)-1:0]      map_entry,
	input  wire logic                         correctable_report_disable,
	input  wire logic                         flag_clear_strobe,
	input  wire logic [dma_err_pkg::FLAG_W-1:0] flag_clear_bits,
	output var  logic                         dma_claim,
	output var  logic                         target_abort,
	output var  logic [WB_N-1:0]              wb_discard,
	output var  logic                         perr_n_o,
	output var  logic                         perr_oe,
	output var  logic [dma_err_pkg::FLAG_W-1:0] diag_control_status_reg,
	output var  logic [dma_err_pkg::PCI_AW-1:0] pci_error_address_reg,
	output var  logic [dma_err_pkg::HOST_AW-1:0] host_bus_error_address_reg,
	output var  logic                         error_regs_locked,
	output var  logic                         cpu_error_interrupt
);
	import dma_err_pkg::*;

	err_flag_if fl ();

	txn_state_t          st_reg, st_next;
	logic [PCI_AW-1:0]   start_reg, start_next;
	logic [PCI_AW-1:0]   pci_error_address_reg_next;
	logic [HOST_AW-1:0]  host_bus_error_address_reg_next;
	logic                claim_next, abort_next, irq_next, lock_next;
	logic [WB_N-1:0]     discard_next;
	flag_vec_t           set_vec, clr_vec, flags_next;
	logic                mismatch, locked;
	logic                ev_dpe, ev_mem, ev_cor, ev_unc, ev_map, ev_any;
	logic                lw_ok, addr_perr;

	dma_par_check u_par (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pci_ad   (pci_ad),
		.pci_cbe_n(pci_cbe_n),
		.pci_par  (pci_par),
		.data_err (ev_dpe),
		.mismatch (mismatch),
		.perr_n_o (perr_n_o),
		.perr_oe  (perr_oe)
	);

	err_flag_bank u_bank (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.fl      (fl.bank)
	);

	// The whole log is one lock; the lost flag alone does not hold it.
	assign locked    = |fl.flags[F_INVALID_MAP_ENTRY_FLAG:F_DPE];
	assign addr_perr = addr_valid & mismatch;

	// Read data parity is never checked here; the master owns it.
	always_comb begin
		ev_dpe = data_valid & (st_reg == TS_WRITE) & mismatch;
		ev_mem = hb_done & hb_needed &
			(hb_map_read ? (dma_cycle_ack == ACK_MAP_ERR)
			             : (dma_cycle_ack == ACK_DMA_ERR));
		lw_ok  = lw_valid & lw_to_pci & ~lw_rmw;
		ev_cor = lw_ok & datapath_error_sideband[SB_CORR] &
			~correctable_report_disable;
		ev_unc = lw_ok & datapath_error_sideband[SB_UNCORR];
		ev_map = map_invalid;
		ev_any = ev_dpe | ev_mem | ev_cor | ev_unc | ev_map;
	end

	always_comb begin
		st_next    = st_reg;
		start_next = start_reg;
		claim_next = 1'b0;
		unique case (st_reg)
			TS_IDLE: begin
				if (addr_valid && addr_hit && !addr_perr) begin
					claim_next = 1'b1;
					start_next = pci_ad;
					st_next    = pci_cbe_n[CMD_WR_BIT] ? TS_WRITE : TS_READ;
				end
			end
			TS_READ, TS_WRITE: begin
				if (txn_end) begin
					st_next = TS_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		abort_next = (st_reg == TS_READ) &
			((ev_mem & hb_for_read) | (ev_unc & lw_for_read) |
			 (ev_map & map_for_read));
		discard_next = '0;
		for (int e = 0; e < WB_N; e++) begin
			discard_next[e] =
				(ev_dpe & (wr_entry == e[$clog2(WB_N)-1:0])) |
				(ev_mem & ~hb_for_read &
				 (hb_entry == e[$clog2(WB_N)-1:0])) |
				(ev_unc & ~lw_for_read &
				 (lw_entry == e[$clog2(WB_N)-1:0])) |
				(ev_map & ~map_for_read &
				 (map_entry == e[$clog2(WB_N)-1:0]));
		end
	end

	always_comb begin
		set_vec   = '0;
		pci_error_address_reg_next = pci_error_address_reg;
		host_bus_error_address_reg_next = host_bus_error_address_reg;
		if (locked) begin
			set_vec[F_LOST] = ev_any;
		end else begin
			set_vec[F_DPE]  = ev_dpe;
			set_vec[F_MEMORY_ERROR_FLAG] = ev_mem;
			set_vec[F_CORRECTABLE_READ_FLAG] = ev_cor;
			set_vec[F_UNCORRECTABLE_READ_FLAG] = ev_unc;
			set_vec[F_INVALID_MAP_ENTRY_FLAG] = ev_map;
			if (ev_dpe || ev_map) begin
				pci_error_address_reg_next = start_reg;
			end
			// map cycle error logs host address
			if (ev_mem) begin
				host_bus_error_address_reg_next = hb_addr;
			end else if (ev_cor || ev_unc) begin
				host_bus_error_address_reg_next = lw_addr;
			end
		end
		clr_vec    = flag_clear_strobe ? flag_clear_bits : '0;
		flags_next = (fl.flags & ~clr_vec) | set_vec;
		lock_next  = |flags_next[F_INVALID_MAP_ENTRY_FLAG:F_DPE];
		irq_next   = |flags_next;
	end

	assign fl.set_vec = set_vec;
	assign fl.clr_vec = clr_vec;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg                     <= TS_IDLE;
			start_reg                  <= PCI_ERROR_ADDRESS_REG_RST;
			dma_claim                  <= 1'b0;
			target_abort               <= 1'b0;
			wb_discard                 <= '0;
			diag_control_status_reg    <= FLAGS_RST;
			pci_error_address_reg      <= PCI_ERROR_ADDRESS_REG_RST;
			host_bus_error_address_reg <= HOST_BUS_ERROR_ADDRESS_REG_RST;
			error_regs_locked          <= 1'b0;
			cpu_error_interrupt        <= 1'b0;
		end else begin
			st_reg                     <= st_next;
			start_reg                  <= start_next;
			dma_claim                  <= claim_next;
			target_abort               <= abort_next;
			wb_discard                 <= discard_next;
			diag_control_status_reg    <= flags_next;
			pci_error_address_reg      <= pci_error_address_reg_next;
			host_bus_error_address_reg <= host_bus_error_address_reg_next;
			error_regs_locked          <= lock_next;
			cpu_error_interrupt        <= irq_next;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_perr_pulse;
		##2 (!perr_n_o && perr_oe);
	endsequence

	chk_perr_delay: assert property (ev_dpe |-> s_perr_pulse)
		else $error("PERR# not driven two clocks after parity error");
	chk_perr_cause: assert property (!perr_n_o |-> $past(ev_dpe, 2))
		else $error("PERR# driven without a write parity error");
	chk_addr_noclaim: assert property (addr_perr |=> !dma_claim)
		else $error("transaction claimed despite address parity error");
	chk_flag_sticky: assert property ($fell(diag_control_status_reg[F_DPE])
		|-> $past(flag_clear_strobe && flag_clear_bits[F_DPE]))
		else $error("write parity flag cleared without a one written");
	chk_irq_event: assert property (ev_any |=> cpu_error_interrupt)
		else $error("error detected but no interrupt");
	chk_irq_holds: assert property ((|diag_control_status_reg)
		|-> cpu_error_interrupt)
		else $error("interrupt dropped while a flag is set");
	chk_lock_stable: assert property ((locked && !flag_clear_strobe)
		|=> $stable(pci_error_address_reg)
		 && $stable(host_bus_error_address_reg))
		else $error("logged address changed while locked");
	chk_cor_disable: assert property ((correctable_report_disable
		&& !ev_cor && !diag_control_status_reg[F_CORRECTABLE_READ_FLAG])
		|=> !diag_control_status_reg[F_CORRECTABLE_READ_FLAG])
		else $error("corrected flag set while reporting disabled");
	chk_abort_unc: assert property ((ev_unc && lw_for_read
		&& st_reg == TS_READ) |=> target_abort)
		else $error("uncorrectable read not target-aborted");
endmodule : pci_dma_error_handler
`default_nettype wire

// File: verification/dma_far_side.sv
// Purpose: Far side of the handler: a PCI DMA master, the host memory
//          controller and the data-path chips.
// Assumes: Every change lands 1 ns after a core_clk rising edge.
// Notes:   Released data lines show the inverse of their last value; strobes drop to zero.
`timescale 1ns/1ps
`default_nettype none
module dma_far_side (
	input  wire logic        core_clk,
	output var  logic        addr_valid,
	output var  logic        data_valid,
	output var  logic [31:0] pci_ad,
	output var  logic [3:0]  pci_cbe_n,
	output var  logic        pci_par,
	output var  logic        hb_done,
	output var  logic [1:0]  dma_cycle_ack,
	output var  logic        lw_valid,
	output var  logic [1:0]  datapath_error_sideband
);
	initial begin
		{addr_valid, data_valid, hb_done, lw_valid} = 4'h0;
		{pci_ad, pci_cbe_n, pci_par} = 37'h0;
		{dma_cycle_ack, datapath_error_sideband} = 4'h0;
	end

	// master owns read parity
	// Only address and write phases are modelled, so the master never
	// reports read-data parity back to the handler.
	task automatic pci_phase(input logic adr, input logic [31:0] ad,
			input logic [3:0] cbe, input logic bad);
		@(posedge core_clk);
		#1;
		addr_valid = adr;
		data_valid = !adr;
		pci_ad = ad;
		pci_cbe_n = cbe;
		pci_par = (^{ad, cbe}) ^ bad;
		@(posedge core_clk);
		#1;
		{addr_valid, data_valid} = 2'h0;
		pci_ad = ~ad;
		pci_cbe_n = ~cbe;
		pci_par = ~pci_par;
	endtask : pci_phase

	// error code ends cycle
	// A failing host cycle ends with whatever code the caller names.
	task automatic side_evt(input logic hb, input logic lw,
			input logic [1:0] ack, input logic [1:0] sb);
		@(posedge core_clk);
		#1;
		hb_done = hb;
		lw_valid = lw;
		dma_cycle_ack = ack;
		datapath_error_sideband = sb;
		@(posedge core_clk);
		#1;
		{hb_done, lw_valid} = 2'h0;
		dma_cycle_ack = ~ack;
		datapath_error_sideband = ~sb;
	endtask : side_evt
endmodule : dma_far_side
`default_nettype wire

// File: verification/pci_dma_error_handler_tb.sv
// Purpose: Self-checking bench for pci_dma_error_handler.
// Assumes: Outputs are registered and settle 1 ns after a clock edge.
// Notes:   Qualifiers are held by the bench; pulses come from the
//          far-side model or from bench_evt.
`timescale 1ns/1ps
`default_nettype none
module pci_dma_error_handler_tb;
	logic        core_clk, rst_n, addr_valid, addr_hit, pci_par;
	logic        data_valid, txn_end, wr_entry, hb_done, hb_map_read;
	logic        hb_for_read, hb_needed, hb_entry, lw_valid, lw_to_pci;
	logic        lw_for_read, lw_rmw, lw_entry, map_invalid, map_for_read;
	logic        map_entry, correctable_report_disable, flag_clear_strobe;
	logic        dma_claim, target_abort, perr_n_o, perr_oe;
	logic        error_regs_locked, cpu_error_interrupt;
	logic [1:0]  dma_cycle_ack, datapath_error_sideband, wb_discard;
	logic [3:0]  pci_cbe_n;
	logic [5:0]  flag_clear_bits, diag_control_status_reg;
	logic [31:0] pci_ad, pci_error_address_reg;
	logic [33:0] hb_addr, lw_addr, host_bus_error_address_reg;
	int          num_errors = 0;
	int          compares = 0;

	pci_dma_error_handler #(.WB_N(2)) dut_u (
		.core_clk, .rst_n, .addr_valid, .addr_hit, .pci_ad, .pci_cbe_n,
		.pci_par, .data_valid, .txn_end, .wr_entry, .hb_done, .dma_cycle_ack,
		.hb_map_read, .hb_for_read, .hb_needed, .hb_entry, .hb_addr,
		.lw_valid, .datapath_error_sideband, .lw_to_pci, .lw_for_read,
		.lw_rmw, .lw_entry, .lw_addr, .map_invalid, .map_for_read,
		.map_entry, .correctable_report_disable, .flag_clear_strobe,
		.flag_clear_bits, .dma_claim, .target_abort, .wb_discard,
		.perr_n_o, .perr_oe, .diag_control_status_reg,
		.pci_error_address_reg, .host_bus_error_address_reg,
		.error_regs_locked, .cpu_error_interrupt
	);

	dma_far_side far_u (
		.core_clk, .addr_valid, .data_valid, .pci_ad, .pci_cbe_n, .pci_par,
		.hb_done, .dma_cycle_ack, .lw_valid, .datapath_error_sideband
	);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// The interrupt is expected exactly when some flag is standing.
	task automatic see(input logic [5:0] fl, input logic ab,
			input logic [1:0] wd);
		chk(diag_control_status_reg, fl);
		chk(target_abort, ab);
		chk(wb_discard, wd);
		chk(cpu_error_interrupt, |fl);
	endtask : see

	task automatic bench_evt(input logic m, input logic t, input logic c,
			input logic [5:0] bits);
		@(posedge core_clk);
		#1;
		map_invalid = m;
		txn_end = t;
		flag_clear_strobe = c;
		flag_clear_bits = bits;
		@(posedge core_clk);
		#1;
		{map_invalid, txn_end, flag_clear_strobe} = 3'h0;
		flag_clear_bits = ~bits;
	endtask : bench_evt

	task automatic give_verdict();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		#40000;
		num_errors++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		{addr_hit, wr_entry, hb_map_read, hb_for_read, hb_needed} = 5'h0;
		{hb_entry, lw_to_pci, lw_for_read, lw_rmw, lw_entry} = 5'h0;
		{map_invalid, map_for_read, map_entry, txn_end} = 4'h0;
		{correctable_report_disable, flag_clear_strobe} = 2'h0;
		flag_clear_bits = 6'h00;
		hb_addr = 34'h2_0000_0100;
		lw_addr = 34'h1_0000_0040;
		repeat (8) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		see(6'h00, 1'b0, 2'h0);
		chk({perr_n_o, perr_oe, error_regs_locked}, 3'b100);
		addr_hit = 1'b1;
		far_u.pci_phase(1'b1, 32'h0000_1240, 4'h7, 1'b1);
		chk(dma_claim, 1'b0);
		see(6'h00, 1'b0, 2'h0);
		far_u.pci_phase(1'b1, 32'h0000_1240, 4'h7, 1'b0);
		chk(dma_claim, 1'b1);
		far_u.pci_phase(1'b0, 32'ha5a5_0001, 4'h0, 1'b0);
		see(6'h00, 1'b0, 2'h0);
		wr_entry = 1'b1;
		far_u.pci_phase(1'b0, 32'h5a5a_0002, 4'h0, 1'b1);
		see(6'h01, 1'b0, 2'h2);
		chk(pci_error_address_reg, 32'h0000_1240);
		chk({perr_n_o, perr_oe}, 2'b10);
		@(posedge core_clk);
		#1;
		chk({perr_n_o, perr_oe}, 2'b01);
		wr_entry = 1'b0;
		far_u.pci_phase(1'b0, 32'h0000_0003, 4'h0, 1'b1);
		chk({perr_n_o, perr_oe}, 2'b10);
		see(6'h21, 1'b0, 2'h1);
		chk(pci_error_address_reg, 32'h0000_1240);
		bench_evt(1'b0, 1'b1, 1'b1, 6'h00);
		see(6'h21, 1'b0, 2'h0);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h01);
		see(6'h20, 1'b0, 2'h0);
		chk(error_regs_locked, 1'b0);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h20);
		see(6'h00, 1'b0, 2'h0);
		far_u.pci_phase(1'b1, 32'h0000_2000, 4'h6, 1'b0);
		hb_for_read = 1'b1;
		far_u.side_evt(1'b1, 1'b0, 2'h3, 2'h0);
		see(6'h00, 1'b0, 2'h0);
		hb_needed = 1'b1;
		far_u.side_evt(1'b1, 1'b0, 2'h3, 2'h0);
		see(6'h02, 1'b1, 2'h0);
		chk(host_bus_error_address_reg, 34'h2_0000_0100);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		{lw_to_pci, lw_for_read, correctable_report_disable} = 3'h7;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h2);
		see(6'h00, 1'b0, 2'h0);
		correctable_report_disable = 1'b0;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h2);
		see(6'h04, 1'b0, 2'h0);
		chk(host_bus_error_address_reg, 34'h1_0000_0040);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		lw_to_pci = 1'b0;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h1);
		see(6'h00, 1'b0, 2'h0);
		{lw_to_pci, lw_rmw} = 2'h3;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h3);
		see(6'h00, 1'b0, 2'h0);
		lw_rmw = 1'b0;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h1);
		see(6'h08, 1'b1, 2'h0);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		map_for_read = 1'b1;
		bench_evt(1'b1, 1'b0, 1'b0, 6'h00);
		see(6'h10, 1'b1, 2'h0);
		chk(pci_error_address_reg, 32'h0000_2000);
		bench_evt(1'b0, 1'b1, 1'b1, 6'h3f);
		far_u.pci_phase(1'b1, 32'h0000_3000, 4'h7, 1'b0);
		{map_for_read, map_entry, hb_for_read} = 3'h2;
		bench_evt(1'b1, 1'b0, 1'b0, 6'h00);
		see(6'h10, 1'b0, 2'h2);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		hb_map_read = 1'b1;
		far_u.side_evt(1'b1, 1'b0, 2'h2, 2'h0);
		see(6'h02, 1'b0, 2'h1);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		hb_map_read = 1'b0;
		far_u.side_evt(1'b1, 1'b0, 2'h0, 2'h0);
		see(6'h00, 1'b0, 2'h0);
		far_u.side_evt(1'b1, 1'b0, 2'h3, 2'h0);
		see(6'h02, 1'b0, 2'h1);
		hb_entry = 1'b1;
		far_u.side_evt(1'b1, 1'b0, 2'h3, 2'h0);
		see(6'h22, 1'b0, 2'h2);
		bench_evt(1'b0, 1'b0, 1'b1, 6'h3f);
		{lw_for_read, lw_entry} = 2'h1;
		far_u.side_evt(1'b0, 1'b1, 2'h0, 2'h1);
		see(6'h08, 1'b0, 2'h2);
		bench_evt(1'b0, 1'b1, 1'b1, 6'h3f);
		give_verdict();
	end
endmodule : pci_dma_error_handler_tb
`default_nettype wire
